// file: design/dpg_pkg.sv
// diagnostic port pattern generator: shared constants and types
// assumes a 50 MHz core clock and a separate link clock for the chip side
`default_nettype none
package dpg_pkg;
  // ==========================================================
  // timing
  localparam int CLK_HZ = 50_000_000;
  localparam int BAUD = 62_500;
  localparam int BAUD_CYC = CLK_HZ / BAUD;
  localparam int SER_PERIOD_US = 820;
  localparam int SER_PERIOD_CYC = (CLK_HZ / 1_000_000) * SER_PERIOD_US;
  localparam int SQ_FREQ_HZ = 610;
  localparam int SQ_HALF_CYC = CLK_HZ / (2 * SQ_FREQ_HZ);
  localparam int CTRL_CLK_MHZ = 4;
  localparam logic [5:0] NCO_STEP = 6'(2 * CTRL_CLK_MHZ);
  localparam logic [5:0] NCO_MOD = 6'(CLK_HZ / 1_000_000);
  localparam logic [1:0] STRAP_SETTLE = 2'h3;
  localparam logic [2:0] STROBE_CYC = 3'h2;
  // ==========================================================
  // fixed values
  localparam logic [7:0] SER_BYTE = 8'h55;
  localparam logic [7:0] ERR_CODE = 8'h32;
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [3:0] RW_ADDR = 4'h3;
  localparam logic [7:0] ODD_PAT8 = 8'haa;
  localparam logic [3:0] ODD_PAT4 = 4'ha;
  localparam logic [7:0] DATA_RST = 8'h00;
  // ==========================================================
  // modes and states
  typedef enum logic [1:0] {
    MODE_ODD_HIGH = 2'b00,
    MODE_EVEN_HIGH = 2'b01,
    MODE_DYNAMIC = 2'b10,
    MODE_RW = 2'b11
  } dpg_mode_type;
  typedef enum logic [1:0] {
    RW_IDLE = 2'b00,
    RW_SETUP = 2'b01,
    RW_STROBE = 2'b10,
    RW_RECOVER = 2'b11
  } dpg_rw_state_type;
  // switch word: high, middle, low
  function automatic dpg_mode_type dpg_decode(input logic [2:0] sw);
    dpg_mode_type m;
    m = MODE_RW;
    if (sw[2]) begin
      if (!sw[0]) begin
        m = MODE_DYNAMIC;
      end else if (sw[1]) begin
        m = MODE_EVEN_HIGH;
      end else begin
        m = MODE_ODD_HIGH;
      end
    end
    return m;
  endfunction
endpackage
`default_nettype wire

// file: design/dpg_ser_if.sv
// diagnostic port pattern generator: link between core and serial sender
// assumes both ends run on the core clock
`default_nettype none
interface dpg_ser_if;
  logic en;
  logic txd;
  logic busy;
  modport tx (input en, output txd, output busy);
  modport ctl (output en, input txd, input busy);
endinterface
`default_nettype wire

// file: design/dpg_sync.sv
// diagnostic port pattern generator: two-stage level synchroniser
// assumes the destination clock and its own asynchronous reset
`default_nettype none
module dpg_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule
`default_nettype wire

// file: design/dpg_serial_tx.sv
// diagnostic port pattern generator: repeating 8n1 byte sender
// assumes the core clock; idle line level is high
`default_nettype none
module dpg_serial_tx
  import dpg_pkg::*;
#(
  parameter int PERIOD_CYC = dpg_pkg::SER_PERIOD_CYC,
  parameter int BIT_CYC = dpg_pkg::BAUD_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  dpg_ser_if.tx sif
);
  logic [15:0] period_r;
  logic [11:0] baud_r;
  logic [3:0] bit_r;
  logic [9:0] shift_r;
  // ==========================================================
  // frame repeat timer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      period_r <= '0;
    end else if (!sif.en || period_r == 16'(PERIOD_CYC - 1)) begin
      period_r <= '0;
    end else begin
      period_r <= period_r + 16'h0001;
    end
  end
  // ==========================================================
  // bit shifter, lsb first, start and stop bits framed
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      baud_r <= '0;
      bit_r <= '0;
      shift_r <= '1;
      sif.busy <= 1'b0;
      sif.txd <= 1'b1;
    end else if (!sif.en) begin
      sif.busy <= 1'b0;
      sif.txd <= 1'b1;
    end else if (period_r == 16'h0000) begin
      shift_r <= {1'b1, SER_BYTE, 1'b0};
      baud_r <= '0;
      bit_r <= '0;
      sif.busy <= 1'b1;
    end else if (sif.busy) begin
      sif.txd <= shift_r[0];
      if (baud_r == 12'(BIT_CYC - 1)) begin
        baud_r <= '0;
        shift_r <= {1'b1, shift_r[9:1]};
        bit_r <= bit_r + 4'h1;
        sif.busy <= (bit_r != 4'h9);
      end else begin
        baud_r <= baud_r + 12'h001;
      end
    end else begin
      sif.txd <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: design/dpg_top.sv
// diagnostic port pattern generator: top level
// assumes switch and jumper pins are asynchronous; link_clk clocks the
// controller chip side, clk (50 MHz) the timing generators.
`default_nettype none
module dpg_top
  import dpg_pkg::*;
#(
  parameter int SQ_HALF = dpg_pkg::SQ_HALF_CYC,
  parameter int SER_PERIOD = dpg_pkg::SER_PERIOD_CYC,
  parameter int SER_BIT = dpg_pkg::BAUD_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic link_clk,
  input wire logic diag_jumper_b,
  input wire logic mode_switch_high,
  input wire logic static_level_switch,
  input wire logic static_dynamic_switch,
  input wire logic [7:0] port1_in,
  output logic diag_jumper_a,
  output logic diag_active,
  output logic [7:0] error_code,
  output logic [7:0] port0_out,
  output logic [7:0] port0_oe,
  output logic [7:0] port1_out,
  output logic [7:0] port1_oe,
  output logic chip_strobe_n,
  output logic chip_rw_n,
  output logic [7:0] read_data,
  output logic controller_clock_pin,
  output logic serial_out_pin
);
  import dpg_pkg::*;

  // ==========================================================
  // jumper strap, caught once after reset release
  logic jumper_low;
  logic [1:0] settle_r;
  logic strap_done_r;

  dpg_sync #(.W(1)) u_jump_sync (
    .clk(clk),
    .arst_n(arst_n),
    .d(~diag_jumper_b),
    .q(jumper_low)
  );

  // one jumper end is held low; the other reads low when shorted
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      diag_jumper_a <= 1'b0;
    end else begin
      diag_jumper_a <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      settle_r <= '0;
    end else if (settle_r != STRAP_SETTLE) begin
      settle_r <= settle_r + 2'h1;
    end
  end

  // latched once after each reset release; jumper removal later has no effect
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      strap_done_r <= 1'b0;
      diag_active <= 1'b0;
    end else if (!strap_done_r && settle_r == STRAP_SETTLE) begin
      strap_done_r <= 1'b1;
      diag_active <= jumper_low;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      error_code <= ERR_NONE;
    end else begin
      error_code <= diag_active ? ERR_CODE : ERR_NONE;
    end
  end

  // ==========================================================
  // 4 MHz controller clock from a fractional accumulator
  logic [5:0] nco_r;
  logic [6:0] nco_sum;

  assign nco_sum = {1'b0, nco_r} + {1'b0, NCO_STEP};

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      nco_r <= '0;
      controller_clock_pin <= 1'b0;
    end else if (!diag_active) begin
      nco_r <= '0;
      controller_clock_pin <= 1'b0;
    end else if (nco_sum >= {1'b0, NCO_MOD}) begin
      nco_r <= 6'(nco_sum - {1'b0, NCO_MOD});
      controller_clock_pin <= ~controller_clock_pin;
    end else begin
      nco_r <= nco_sum[5:0];
    end
  end

  // ==========================================================
  // repeating serial byte
  dpg_ser_if ser ();

  assign ser.en = diag_active;
  assign serial_out_pin = ser.txd;

  dpg_serial_tx #(
    .PERIOD_CYC(SER_PERIOD),
    .BIT_CYC(SER_BIT)
  ) u_ser (
    .clk(clk),
    .arst_n(arst_n),
    .sif(ser.tx)
  );

  // ==========================================================
  // square wave for the dynamic mode
  logic [15:0] sq_cnt_r;
  logic sq_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sq_cnt_r <= '0;
      sq_r <= 1'b0;
    end else if (sq_cnt_r == 16'(SQ_HALF - 1)) begin
      sq_cnt_r <= '0;
      sq_r <= ~sq_r;
    end else begin
      sq_cnt_r <= sq_cnt_r + 16'h0001;
    end
  end

  // ==========================================================
  // link domain reset, asserted at once, released on link_clk
  logic lrst_meta_r;
  logic lrst_n_r;

  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      lrst_meta_r <= 1'b0;
      lrst_n_r <= 1'b0;
    end else begin
      lrst_meta_r <= 1'b1;
      lrst_n_r <= lrst_meta_r;
    end
  end

  // ==========================================================
  // crossings into the link domain
  logic [3:0] word_l;
  logic [3:0] word_seen_r;
  logic [3:0] word_ok_r;
  logic active_l;
  logic sq_l;
  dpg_mode_type mode_l;

  // enable and switches cross together as one word
  dpg_sync #(.W(4)) u_sw_sync (
    .clk(link_clk),
    .arst_n(lrst_n_r),
    .d({diag_active, mode_switch_high, static_level_switch, static_dynamic_switch}),
    .q(word_l)
  );

  dpg_sync #(.W(1)) u_lvl_sync (
    .clk(link_clk),
    .arst_n(lrst_n_r),
    .d(sq_r),
    .q(sq_l)
  );

  // bits may land on different edges; a word is taken once two samples
  // agree, so a half-crossed word never shows as a passing mode
  always_ff @(posedge link_clk or negedge lrst_n_r) begin
    if (!lrst_n_r) begin
      word_seen_r <= '0;
    end else begin
      word_seen_r <= word_l;
    end
  end

  always_ff @(posedge link_clk or negedge lrst_n_r) begin
    if (!lrst_n_r) begin
      word_ok_r <= '0;
    end else if (word_l == word_seen_r) begin
      word_ok_r <= word_l;
    end
  end

  assign active_l = word_ok_r[3];
  assign mode_l = dpg_decode(word_ok_r[2:0]);

  // ==========================================================
  // chip access sequencer
  dpg_rw_state_type st_r;
  logic [2:0] stb_cnt_r;
  logic write_r;
  logic [7:0] data_r;
  logic run_rw;
  logic rw_hold;
  dpg_mode_type mode_eff;

  assign run_rw = active_l && (mode_l == MODE_RW);
  // an access already begun runs to its end, whatever the switches do
  assign rw_hold = run_rw || (st_r != RW_IDLE);
  assign mode_eff = rw_hold ? MODE_RW : mode_l;

  always_ff @(posedge link_clk or negedge lrst_n_r) begin
    if (!lrst_n_r) begin
      st_r <= RW_IDLE;
      stb_cnt_r <= '0;
    end else begin
      case (st_r)
        RW_IDLE: begin
          stb_cnt_r <= '0;
          if (run_rw) begin
            st_r <= RW_SETUP;
          end
        end
        RW_SETUP: begin
          st_r <= RW_STROBE;
          stb_cnt_r <= '0;
        end
        RW_STROBE: begin
          stb_cnt_r <= stb_cnt_r + 3'h1;
          if (stb_cnt_r == STROBE_CYC - 3'h1) begin
            st_r <= RW_RECOVER;
          end
        end
        RW_RECOVER: begin
          // leave only between accesses, never with the strobe low
          st_r <= run_rw ? RW_SETUP : RW_IDLE;
        end
        default: begin
          st_r <= RW_IDLE;
        end
      endcase
    end
  end

  // alternate write and read; data steps after each access
  always_ff @(posedge link_clk or negedge lrst_n_r) begin
    if (!lrst_n_r) begin
      write_r <= 1'b1;
      data_r <= DATA_RST;
    end else if (st_r == RW_RECOVER) begin
      write_r <= ~write_r;
      data_r <= data_r + 8'h01;
    end
  end

  // read data is taken at the end of the strobe
  always_ff @(posedge link_clk or negedge lrst_n_r) begin
    if (!lrst_n_r) begin
      read_data <= DATA_RST;
    end else if (!write_r && st_r == RW_STROBE
                 && stb_cnt_r == STROBE_CYC - 3'h1) begin
      read_data <= port1_in;
    end
  end

  // ==========================================================
  // port drivers, all registered in the link domain
  always_ff @(posedge link_clk or negedge lrst_n_r) begin
    if (!lrst_n_r) begin
      chip_strobe_n <= 1'b1;
      chip_rw_n <= 1'b1;
    end else begin
      chip_strobe_n <= !(st_r == RW_SETUP) && !(st_r == RW_STROBE
                       && stb_cnt_r != STROBE_CYC - 3'h1);
      chip_rw_n <= rw_hold ? !write_r : 1'b1;
    end
  end

  always_ff @(posedge link_clk or negedge lrst_n_r) begin
    if (!lrst_n_r) begin
      port0_out <= '0;
      port0_oe <= '0;
      port1_out <= '0;
      port1_oe <= '0;
    end else if (!active_l) begin
      port0_out <= '0;
      port0_oe <= '0;
      port1_out <= '0;
      port1_oe <= '0;
    end else begin
      port0_out[7:4] <= 4'h0;
      port0_oe[7:4] <= 4'h0;
      port0_oe[3:0] <= 4'hf;
      case (mode_eff)
        MODE_ODD_HIGH: begin
          port0_out[3:0] <= ODD_PAT4;
          port1_out <= ODD_PAT8;
          port1_oe <= 8'hff;
        end
        MODE_EVEN_HIGH: begin
          port0_out[3:0] <= ~ODD_PAT4;
          port1_out <= ~ODD_PAT8;
          port1_oe <= 8'hff;
        end
        MODE_DYNAMIC: begin
          port0_out[3:0] <= sq_l ? ~ODD_PAT4 : ODD_PAT4;
          port1_out <= sq_l ? ~ODD_PAT8 : ODD_PAT8;
          port1_oe <= 8'hff;
        end
        MODE_RW: begin
          port0_out[3:0] <= RW_ADDR;
          port1_out <= data_r;
          port1_oe <= write_r ? 8'hff : 8'h00;
        end
        default: begin
          port0_out[3:0] <= 4'h0;
          port1_out <= '0;
          port1_oe <= '0;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// file: bench/dpg_top_asserts.sv
// checker: timing relations at the pattern generator pins
// assumes it is bound onto dpg_top; both clock domains share arst_n
`default_nettype none
module dpg_top_asserts (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic link_clk,
  input wire logic diag_active,
  input wire logic [7:0] error_code,
  input wire logic [7:0] port0_out,
  input wire logic [7:0] port0_oe,
  input wire logic [7:0] port1_out,
  input wire logic [7:0] port1_oe,
  input wire logic chip_strobe_n,
  input wire logic chip_rw_n,
  input wire logic controller_clock_pin,
  input wire logic serial_out_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================
  // core clock domain
  a_error_shown: assert property (@(posedge clk) disable iff (!arst_n)
    diag_active && $past(diag_active) |-> error_code == 8'h32) else $error("error code not shown");
  a_active_held: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(diag_active) |=> diag_active [*8]) else $error("diagnostics left");
  a_ctrl_clk_half: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(controller_clock_pin) |-> controller_clock_pin [*6] ##[1:2] !controller_clock_pin)
    else $error("controller clock high time");
  a_serial_idle: assert property (@(posedge clk) disable iff (!arst_n)
    !diag_active |-> serial_out_pin) else $error("serial line not idle");
  // ==========================================
  // link clock domain
  a_upper_undriven: assert property (@(posedge link_clk) disable iff (!arst_n)
    port0_oe[7:4] == 4'h0) else $error("port0 upper nibble driven");
  a_idle_quiet: assert property (@(posedge link_clk) disable iff (!arst_n)
    !diag_active |-> port0_oe == 8'h00 && port1_oe == 8'h00 && chip_strobe_n) else $error("driven while idle");
  a_strobe_two: assert property (@(posedge link_clk) disable iff (!arst_n)
    $fell(chip_strobe_n) |=> !chip_strobe_n ##1 chip_strobe_n) else $error("strobe width");
  a_rw_address: assert property (@(posedge link_clk) disable iff (!arst_n)
    !chip_strobe_n |-> port0_out[3:0] == 4'h3 && port0_oe == 8'h0f) else $error("access address");
  a_rw_direction: assert property (@(posedge link_clk) disable iff (!arst_n)
    !chip_strobe_n |-> port1_oe == (chip_rw_n ? 8'h00 : 8'hff)) else $error("data direction");
  a_rw_alternate: assert property (@(posedge link_clk) disable iff (!arst_n)
    $fell(chip_strobe_n) ##4 $fell(chip_strobe_n) |-> chip_rw_n != $past(chip_rw_n, 4))
    else $error("access kind not alternating");
  a_write_step: assert property (@(posedge link_clk) disable iff (!arst_n)
    $fell(chip_strobe_n) && !chip_rw_n ##4 $fell(chip_strobe_n) ##4 $fell(chip_strobe_n)
    |-> port1_out == 8'($past(port1_out, 8) + 8'h02)) else $error("data step");
endmodule
bind dpg_top dpg_top_asserts i_dpg_top_asserts (.clk(clk), .arst_n(arst_n), .link_clk(link_clk),
  .diag_active(diag_active), .error_code(error_code), .port0_out(port0_out), .port0_oe(port0_oe),
  .port1_out(port1_out), .port1_oe(port1_oe), .chip_strobe_n(chip_strobe_n), .chip_rw_n(chip_rw_n),
  .controller_clock_pin(controller_clock_pin), .serial_out_pin(serial_out_pin));
`default_nettype wire

// file: bench/dpg_chip_model.sv
// partner model: one register of the bus controller chip
// assumes strobe, direction and data from the generator on link_clk
`default_nettype none
module dpg_chip_model (
  input wire logic link_clk,
  input wire logic chip_strobe_n,
  input wire logic chip_rw_n,
  input wire logic [7:0] port1_out,
  output logic [7:0] port1_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] held_r;
  logic [7:0] junk_r;
  initial begin
    held_r = 8'h00;
    junk_r = 8'h3c;
  end
  // ==========================================
  // latch writes, answer reads with the inverse
  always @(posedge link_clk) begin
    if (!chip_strobe_n && !chip_rw_n) begin
      held_r <= port1_out;
    end
    junk_r <= ~junk_r;
  end
  // released bus shows a changing pattern
  assign port1_in = (!chip_strobe_n && chip_rw_n) ? ~held_r : junk_r;
endmodule
`default_nettype wire

// file: bench/tb_diag_port_pattern_gen.sv
// testbench: pattern generator modes, timing outputs and entry/exit
// assumes short timing parameters and the chip model on the data port
`default_nettype none
module tb_diag_port_pattern_gen;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int SQH = 20;
  localparam int SPER = 200;
  localparam int SBIT = 8;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic arst_n = 1'b0;
  logic diag_jumper_b = 1'b0;
  logic mode_switch_high = 1'b1;
  logic static_level_switch = 1'b0;
  logic static_dynamic_switch = 1'b1;
  logic [7:0] port1_in;
  logic diag_jumper_a, diag_active, chip_strobe_n, chip_rw_n, controller_clock_pin, serial_out_pin;
  logic [7:0] error_code, port0_out, port0_oe, port1_out, port1_oe, read_data;
  int err_total = 0;
  int compares = 0;
  always #10 clk = ~clk;
  initial begin
    #7;
    forever #15 link_clk = ~link_clk;
  end
  // only the chip model sits on the data port, no other instrument
  dpg_top #(.SQ_HALF(SQH), .SER_PERIOD(SPER), .SER_BIT(SBIT)) i_dpg_top (.clk(clk), .arst_n(arst_n),
    .link_clk(link_clk), .diag_jumper_b(diag_jumper_b), .mode_switch_high(mode_switch_high),
    .static_level_switch(static_level_switch), .static_dynamic_switch(static_dynamic_switch),
    .port1_in(port1_in), .diag_jumper_a(diag_jumper_a), .diag_active(diag_active), .error_code(error_code),
    .port0_out(port0_out), .port0_oe(port0_oe), .port1_out(port1_out), .port1_oe(port1_oe),
    .chip_strobe_n(chip_strobe_n), .chip_rw_n(chip_rw_n), .read_data(read_data),
    .controller_clock_pin(controller_clock_pin), .serial_out_pin(serial_out_pin));
  dpg_chip_model i_dpg_chip_model (.link_clk(link_clk), .chip_strobe_n(chip_strobe_n),
    .chip_rw_n(chip_rw_n), .port1_out(port1_out), .port1_in(port1_in));
  // ==========================================
  // helpers
  task automatic close_out();
    $display("compares %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask
  task automatic do_reset();
    @(negedge clk);
    arst_n = 1'b0;
    repeat (6) @(negedge clk);
    arst_n = 1'b1;
  endtask
  task automatic set_sw(input logic [2:0] s);
    @(negedge clk);
    {mode_switch_high, static_level_switch, static_dynamic_switch} = s;
  endtask
  task automatic lwait(input int n);
    repeat (n) @(posedge link_clk);
    #1;
  endtask
  task automatic wait_strobe(input logic lvl);
    int n;
    n = 0;
    while (chip_strobe_n !== lvl && n < 40) begin
      lwait(1);
      n++;
    end
    chk(chip_strobe_n === lvl, "strobe wait");
  endtask
  // ==========================================
  // scenarios
  task automatic t_enter();
    repeat (12) @(negedge clk);
    chk(diag_active === 1'b1 && error_code === 8'h32, "entry");
    chk(diag_jumper_a === 1'b0, "jumper drive");
    $display("test enter done");
  endtask
  task automatic t_static();
    logic [7:0] pat;
    for (int i = 0; i < 2; i++) begin
      pat = i ? 8'h55 : 8'haa;
      set_sw(i ? 3'b111 : 3'b101);
      lwait(6);
      chk(port1_out === pat && port0_out[3:0] === pat[3:0], "static level");
      chk(port1_oe === 8'hff && port0_oe === 8'h0f, "static drive");
    end
    $display("test static done");
  endtask
  task automatic t_dynamic();
    int edges;
    int highs;
    logic [7:0] prev;
    for (int i = 0; i < 2; i++) begin
      set_sw(i ? 3'b110 : 3'b100);
      lwait(6);
      edges = 0;
      highs = 0;
      prev = port1_out;
      chk(port1_oe === 8'hff && port0_oe === 8'h0f, "dynamic drive");
      repeat (40 * SQH) begin
        @(negedge clk);
        chk((port1_out === 8'haa || port1_out === 8'h55) && port0_out[3:0] === port1_out[3:0], "phase");
        edges += int'(port1_out !== prev);
        highs += int'(port1_out[0] === 1'b1);
        prev = port1_out;
      end
      chk(edges >= 39 && edges <= 41, "square rate");
      chk(highs >= 19 * SQH && highs <= 21 * SQH, "square duty");
    end
    $display("test dynamic done");
  endtask
  task automatic t_serial();
    int n;
    logic [9:0] frame;
    frame = {1'b1, 8'h55, 1'b0};
    n = 0;
    while (n < 2 * SBIT) begin
      @(negedge clk);
      n = (serial_out_pin === 1'b1) ? n + 1 : 0;
    end
    n = 0;
    while (serial_out_pin !== 1'b0 && n < SPER + 20) begin
      @(negedge clk);
      n++;
    end
    repeat (SBIT / 2) @(negedge clk);
    for (int k = 0; k < 10; k++) begin
      chk(serial_out_pin === frame[k], "serial bit");
      repeat (SBIT) @(negedge clk);
    end
    n = SBIT / 2 + 10 * SBIT;
    while (serial_out_pin !== 1'b0 && n < SPER + 20) begin
      @(negedge clk);
      n++;
    end
    chk(n >= SPER - 1 && n <= SPER + 1, "frame period");
    $display("test serial done");
  endtask
  task automatic t_clock();
    int rises;
    logic prev;
    rises = 0;
    prev = controller_clock_pin;
    repeat (1000) begin
      @(negedge clk);
      rises += int'(controller_clock_pin === 1'b1 && prev === 1'b0);
      prev = controller_clock_pin;
    end
    chk(rises >= 79 && rises <= 81, "controller clock rate");
    $display("test clock done");
  endtask
  task automatic t_rw();
    logic [7:0] exp_d;
    logic [7:0] last_w;
    logic rw;
    exp_d = 8'h00;
    last_w = 8'h00;
    set_sw(3'b011);
    for (int i = 0; i < 6; i++) begin
      wait_strobe(1'b0);
      rw = chip_rw_n;
      chk(rw === i[0], "access order");
      chk(port1_out === exp_d && port0_out[3:0] === 4'h3, "address or data");
      if (!rw) last_w = port1_out;
      if (i == 5) set_sw(3'b101);
      wait_strobe(1'b1);
      if (rw) chk(read_data === ~last_w, "read data");
      exp_d++;
    end
    lwait(8);
    chk(chip_strobe_n === 1'b1 && port1_out === 8'haa, "mode change");
    $display("test rw done");
  endtask
  task automatic t_leave();
    @(negedge clk);
    diag_jumper_b = 1'b1;
    repeat (20) @(negedge clk);
    chk(diag_active === 1'b1 && error_code === 8'h32, "left while running");
    do_reset();
    repeat (20) @(negedge clk);
    chk(diag_active === 1'b0 && error_code === 8'h00, "entered without jumper");
    chk(port0_oe === 8'h00 && port1_oe === 8'h00 && chip_strobe_n === 1'b1, "driven when idle");
    $display("test leave done");
  endtask
  // ==========================================
  // main sequence and watchdog
  initial begin
    do_reset();
    t_enter();
    t_static();
    t_dynamic();
    t_serial();
    t_clock();
    t_rw();
    t_leave();
    close_out();
  end
  initial begin
    #400000;
    err_total++;
    close_out();
  end
endmodule
`default_nettype wire
